// file: logic/frame_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssi_readout_params.svh"

module frame_decoder (
    input wire logic [24:0] frame,
    input wire ssi_readout_pkg::layout_type layout,
    input wire logic [3:0] step_bits,
    input wire logic [3:0] turn_bits,
    output logic [24:0] position
);

    // Each binary bit is the XOR of the gray bits at and above it.
    function automatic logic [24:0] gray_to_bin(input logic [24:0] g);
        logic [24:0] b;
        b[24] = g[24];
        for (int i = 23; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin

    function automatic logic [24:0] low_mask(input logic [4:0] w);
        return (25'h0000001 << w) - 25'h0000001;
    endfunction : low_mask

    logic [24:0] bin;
    logic [3:0] pad;
    logic [4:0] width;

    // Tree layouts left-align the steps, so the pad is shifted away.
    always_comb begin
        bin = gray_to_bin(frame); // [R1] [R18]
        pad = 4'(`STEP_FIELD - step_bits);
        width = 5'(step_bits) + 5'(turn_bits);
        case (layout)
            ssi_readout_pkg::LAYOUT_HALF13,
            ssi_readout_pkg::LAYOUT_HALF25: begin
                position = ((bin & low_mask(5'(`STEP_FIELD))) >> pad) & low_mask(5'(step_bits)); // [R4] [R18]
            end
            ssi_readout_pkg::LAYOUT_FIR25: begin
                position = (bin >> pad) & low_mask(width); // [R18]
            end
            default: begin
                position = bin & low_mask(width); // [R18]
            end
        endcase
    end

endmodule : frame_decoder
`default_nettype wire

// file: logic/ssi_readout.sv
// Operation
// R1: Accept Gray-coded positions only, never binary.
// R2: Frames arrive serially with clock and data.
// R3: Support 13/25-bit half, right, fir-tree layouts.
// R4: Decode 25-bit half fir-tree as single-turn.
// R5: One encoder increment equals one position count.
// R6: Listen-in mode never drives clock, only samples.
// R7: External master clocks frames during listen-in.
// R8: Listen-in uses master settings, ignores rate.
// R9: Listen-in offers fir-tree or right-justified lengths.
// R10: Encoder monostable lies between 15 and 64 us.
// R11: At 125 kHz frames take 112/208 us.
// R12: At 250/500 kHz frames take 56/104, 28/52.
// R13: At 1 MHz frames take 14/26 us.
// R14: Latency at least one frame plus cam.
// R15: Latency at most two frames plus monostable.
// R16: Programmable encoder latency bound likewise kept short.
// R17: Frame error and wire break report as external.
// R18: Gray to binary and layout extraction before output.
// R19: Flag frame error on wrong idle framing.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ssi_readout_params.svh"

module ssi_readout (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enc_clk_i,
    output logic enc_clk_o,
    output logic enc_clk_oe,
    input wire logic enc_data_i,
    output logic [24:0] position,
    output logic position_valid,
    output logic external_fault_indicator,
    output logic internal_fault_indicator,
    output logic irq
);

    ssi_readout_pkg::state_type s_q;
    ssi_readout_pkg::state_type s_d;
    logic [24:0] dec_position;

    // Link half-period for the chosen rate.
    function automatic logic [7:0] half_cycles(input ssi_readout_pkg::rate_type r);
        case (r)
            ssi_readout_pkg::RATE_125K: return 8'(`HALF_CYC(`RATE_125_KHZ));
            ssi_readout_pkg::RATE_250K: return 8'(`HALF_CYC(`RATE_250_KHZ));
            ssi_readout_pkg::RATE_500K: return 8'(`HALF_CYC(`RATE_500_KHZ));
            default: return 8'(`HALF_CYC(`RATE_1000_KHZ));
        endcase
    endfunction : half_cycles

    // Data bits per frame of this layout.
    function automatic logic [4:0] frame_bits(input ssi_readout_pkg::layout_type l);
        case (l)
            ssi_readout_pkg::LAYOUT_HALF13,
            ssi_readout_pkg::LAYOUT_RJ13: return `FRAME_SHORT;
            default: return `FRAME_LONG;
        endcase
    endfunction : frame_bits

    // An undecodable setting counts as an internal fault.
    function automatic logic cfg_bad(input ssi_readout_pkg::settings_type c);
        logic bad;
        bad = (c.layout > ssi_readout_pkg::LAYOUT_HALF25) || (c.step_bits > `STEP_FIELD)
            || (c.turn_bits > `TURN_FIELD) || (c.step_bits == 4'h0);
        // Only the fir-tree and right-justified lengths exist when listening.
        if (c.listen && (c.layout == ssi_readout_pkg::LAYOUT_HALF13 || c.layout == ssi_readout_pkg::LAYOUT_HALF25)) begin
            bad = 1'b1; // [R9]
        end
        return bad;
    endfunction : cfg_bad

    frame_decoder u_decoder (
        .frame(s_q.shift),
        .layout(s_q.cfg.layout),
        .step_bits(s_q.cfg.step_bits),
        .turn_bits(s_q.cfg.turn_bits),
        .position(dec_position)
    );

    logic setup_rd;
    logic access_wr;
    logic addr_ok;
    logic clk_fall;
    logic tick;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic [4:0] nbits;

    // Zero wait states; read data is latched in the setup cycle.
    assign pready = 1'b1;
    assign prdata = s_q.prdata;
    assign setup_rd = psel && !penable;
    assign access_wr = psel && penable && pwrite;
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `REG_IRQ_ENABLE);
    assign pslverr = psel && penable && !addr_ok;

    // Link helpers read the synchronised copies only.
    assign clk_fall = s_q.clk_prev && !s_q.clk_s2;
    assign tick = (s_q.div_cnt == 8'h00);
    assign nbits = frame_bits(s_q.cfg.layout);

    assign enc_clk_o = s_q.clk_out;
    assign enc_clk_oe = s_q.clk_oe;
    assign position = s_q.position;
    assign position_valid = s_q.valid;
    assign external_fault_indicator = s_q.frame_err || s_q.wire_break; // [R17]
    assign internal_fault_indicator = s_q.int_fault;
    assign irq = |(s_q.irq_status & s_q.irq_en);

    // Next state of the whole block.
    always_comb begin
        s_d = s_q;
        ev_set = 4'h0;
        ev_clr = 4'h0;

        // Two flip-flops on each pin.
        s_d.clk_s1 = enc_clk_i;
        s_d.clk_s2 = s_q.clk_s1;
        s_d.clk_prev = s_q.clk_s2;
        s_d.data_s1 = enc_data_i;
        s_d.data_s2 = s_q.data_s1;

        // Register reads.
        if (setup_rd) begin
            case (paddr)
                `REG_CTRL: begin
                    s_d.prdata = 32'h00000000;
                    s_d.prdata[`CTRL_EN_BIT] = s_q.cfg.enable;
                    s_d.prdata[`CTRL_LISTEN_BIT] = s_q.cfg.listen;
                    s_d.prdata[`CTRL_LAYOUT_LSB +: 3] = s_q.cfg.layout;
                    s_d.prdata[`CTRL_RATE_LSB +: 2] = s_q.cfg.rate;
                end
                `REG_CONFIG: begin
                    s_d.prdata = 32'h00000000;
                    s_d.prdata[`CONFIG_STEP_LSB +: 4] = s_q.cfg.step_bits;
                    s_d.prdata[`CONFIG_TURN_LSB +: 4] = s_q.cfg.turn_bits;
                end
                `REG_STATUS: begin
                    s_d.prdata = 32'h00000000;
                    s_d.prdata[`STAT_BUSY_BIT] = s_q.state inside {ssi_readout_pkg::ST_LOW, ssi_readout_pkg::ST_HIGH,
                        ssi_readout_pkg::ST_LISTEN_RX};
                    s_d.prdata[`STAT_FRAME_ERR_BIT] = s_q.frame_err;
                    s_d.prdata[`STAT_WIRE_BREAK_BIT] = s_q.wire_break;
                    s_d.prdata[`STAT_EXT_FAULT_BIT] = s_q.frame_err || s_q.wire_break; // [R17]
                    s_d.prdata[`STAT_INT_FAULT_BIT] = s_q.int_fault;
                    s_d.prdata[`STAT_VALID_BIT] = s_q.valid;
                end
                `REG_POSITION: s_d.prdata = {7'h00, s_q.position};
                `REG_RAW: s_d.prdata = {7'h00, s_q.raw};
                `REG_IRQ_STATUS: s_d.prdata = {28'h0000000, s_q.irq_status};
                `REG_IRQ_ENABLE: s_d.prdata = {28'h0000000, s_q.irq_en};
                default: s_d.prdata = 32'h00000000;
            endcase
        end

        // Writes land at the access edge only.
        if (access_wr) begin
            case (paddr)
                `REG_CTRL: begin
                    s_d.cfg.enable = pwdata[`CTRL_EN_BIT];
                    s_d.cfg.listen = pwdata[`CTRL_LISTEN_BIT];
                    s_d.cfg.layout = ssi_readout_pkg::layout_type'(pwdata[`CTRL_LAYOUT_LSB +: 3]);
                    s_d.cfg.rate = ssi_readout_pkg::rate_type'(pwdata[`CTRL_RATE_LSB +: 2]);
                end
                `REG_CONFIG: begin
                    s_d.cfg.step_bits = pwdata[`CONFIG_STEP_LSB +: 4]; // [R8]
                    s_d.cfg.turn_bits = pwdata[`CONFIG_TURN_LSB +: 4]; // [R8]
                end
                `REG_IRQ_CLEAR: ev_clr = pwdata[3:0];
                `REG_IRQ_ENABLE: s_d.irq_en = pwdata[3:0];
                default: ;
            endcase
        end

        // One enable pulse per link half-period while clocking.
        if (s_q.state inside {ssi_readout_pkg::ST_LOW, ssi_readout_pkg::ST_HIGH}) begin
            s_d.div_cnt = tick ? 8'(half_cycles(s_q.cfg.rate) - 8'h01) : 8'(s_q.div_cnt - 8'h01); // [R11] [R12] [R13]
        end

        case (s_q.state)
            // A bad setting is refused at enable and reported as internal.
            ssi_readout_pkg::ST_IDLE: begin
                s_d.clk_out = 1'b1;
                s_d.clk_oe = 1'b0;
                s_d.gap_cnt = 12'h000;
                if (s_q.cfg.enable) begin
                    if (cfg_bad(s_q.cfg)) begin
                        s_d.int_fault = 1'b1;
                        ev_set[`IRQ_CFG_ERR_BIT] = 1'b1;
                        s_d.cfg.enable = 1'b0;
                    end else if (s_q.cfg.listen) begin
                        s_d.int_fault = 1'b0;
                        s_d.state = ssi_readout_pkg::ST_LISTEN_WAIT;
                    end else begin
                        s_d.int_fault = 1'b0;
                        s_d.clk_oe = 1'b1;
                        s_d.state = ssi_readout_pkg::ST_MONO;
                    end
                end
            end
            // Disable releases the clock at once; otherwise wait out the monostable.
            ssi_readout_pkg::ST_MONO: begin
                s_d.clk_out = 1'b1;
                if (!s_q.cfg.enable || s_q.cfg.listen) begin
                    s_d.clk_oe = 1'b0;
                    s_d.state = ssi_readout_pkg::ST_IDLE;
                end else if (s_q.gap_cnt != 12'(`MONO_MAX_CYC)) begin
                    s_d.gap_cnt = 12'(s_q.gap_cnt + 12'h001); // [R10] [R15]
                end else if (!s_q.data_s2) begin
                    s_d.wire_break = 1'b1; // [R17]
                    ev_set[`IRQ_WIRE_BREAK_BIT] = 1'b1;
                    s_d.gap_cnt = 12'h000;
                end else begin
                    s_d.wire_break = 1'b0;
                    s_d.clk_out = 1'b0; // [R2]
                    s_d.bit_cnt = 5'h00;
                    s_d.shift = 25'h0000000;
                    s_d.div_cnt = 8'(half_cycles(s_q.cfg.rate) - 8'h01);
                    s_d.state = ssi_readout_pkg::ST_LOW;
                end
            end
            ssi_readout_pkg::ST_LOW: begin
                if (tick) begin
                    s_d.clk_out = 1'b1;
                    s_d.state = ssi_readout_pkg::ST_HIGH;
                end
            end
            // Bits are taken at the end of each high half; one extra period closes the frame.
            ssi_readout_pkg::ST_HIGH: begin
                if (tick) begin
                    if (s_q.bit_cnt != nbits) begin
                        s_d.shift = {s_q.shift[23:0], s_q.data_s2}; // [R2] [R3]
                        s_d.bit_cnt = 5'(s_q.bit_cnt + 5'h01);
                        s_d.clk_out = 1'b0;
                        s_d.state = ssi_readout_pkg::ST_LOW;
                    end else begin
                        s_d.gap_cnt = 12'h000;
                        s_d.state = ssi_readout_pkg::ST_MONO;
                        // Data stays low during the monostable time.
                        if (s_q.data_s2) begin
                            s_d.frame_err = 1'b1; // [R19]
                            ev_set[`IRQ_FRAME_ERR_BIT] = 1'b1;
                        end else begin
                            s_d.frame_err = 1'b0;
                            s_d.raw = s_q.shift;
                            s_d.position = dec_position; // [R5] [R14] [R16] [R18]
                            s_d.valid = 1'b1;
                            ev_set[`IRQ_DONE_BIT] = 1'b1;
                        end
                    end
                end
            end
            // The other master owns the clock; a long low clock means a broken line.
            ssi_readout_pkg::ST_LISTEN_WAIT: begin
                s_d.clk_oe = 1'b0; // [R6] [R7]
                s_d.gap_cnt = s_q.clk_s2 ? 12'h000 : 12'(s_q.gap_cnt + 12'h001);
                if (!s_q.cfg.enable || !s_q.cfg.listen) begin
                    s_d.state = ssi_readout_pkg::ST_IDLE;
                end else if (s_q.gap_cnt == 12'(`MONO_MAX_CYC)) begin
                    s_d.wire_break = 1'b1; // [R17]
                    ev_set[`IRQ_WIRE_BREAK_BIT] = 1'b1;
                    s_d.gap_cnt = 12'h000;
                end else if (clk_fall) begin
                    s_d.wire_break = 1'b0;
                    s_d.bit_cnt = 5'h00;
                    s_d.shift = 25'h0000000;
                    s_d.gap_cnt = 12'h000;
                    if (!s_q.data_s2) begin
                        s_d.frame_err = 1'b1; // [R19]
                        ev_set[`IRQ_FRAME_ERR_BIT] = 1'b1;
                    end else begin
                        s_d.state = ssi_readout_pkg::ST_LISTEN_RX; // [R6]
                    end
                end
            end
            // Each later fall ends a bit; a pause inside a frame breaks it.
            ssi_readout_pkg::ST_LISTEN_RX: begin
                s_d.clk_oe = 1'b0; // [R6]
                if (clk_fall) begin
                    s_d.gap_cnt = 12'h000;
                    s_d.shift = {s_q.shift[23:0], s_q.data_s2}; // [R6] [R9]
                    s_d.bit_cnt = 5'(s_q.bit_cnt + 5'h01);
                    if (5'(s_q.bit_cnt + 5'h01) == nbits) begin
                        s_d.state = ssi_readout_pkg::ST_LISTEN_WAIT;
                        s_d.frame_err = 1'b0;
                        s_d.raw = {s_q.shift[23:0], s_q.data_s2};
                        s_d.valid = 1'b1;
                        ev_set[`IRQ_DONE_BIT] = 1'b1;
                    end
                end else if (s_q.clk_s2) begin
                    s_d.gap_cnt = 12'(s_q.gap_cnt + 12'h001);
                    if (s_q.gap_cnt == 12'(`MONO_MIN_CYC)) begin
                        s_d.frame_err = 1'b1; // [R19]
                        ev_set[`IRQ_FRAME_ERR_BIT] = 1'b1;
                        s_d.gap_cnt = 12'h000;
                        s_d.state = ssi_readout_pkg::ST_LISTEN_WAIT;
                    end
                end
            end
            default: s_d.state = ssi_readout_pkg::ST_IDLE;
        endcase

        // A listened frame is decoded one cycle after capture.
        if (s_q.state == ssi_readout_pkg::ST_LISTEN_WAIT && s_q.bit_cnt == nbits && s_q.raw == s_q.shift
            && s_q.valid) begin
            s_d.position = dec_position; // [R8] [R14] [R18]
        end

        // Sticky flags: an event wins over a clear in the same cycle.
        s_d.irq_status = (s_q.irq_status & ~ev_clr) | ev_set;
    end

    // One register for the whole state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.state <= ssi_readout_pkg::ST_IDLE;
            s_q.cfg.layout <= ssi_readout_pkg::LAYOUT_HALF13;
            s_q.cfg.rate <= ssi_readout_pkg::RATE_125K;
            s_q.cfg.enable <= 1'(`CTRL_RST >> `CTRL_EN_BIT);
            s_q.cfg.step_bits <= `STEP_RST;
            s_q.cfg.turn_bits <= `TURN_RST;
            s_q.irq_en <= `IRQ_EN_RST;
            s_q.clk_out <= 1'b1;
            s_q.clk_s1 <= 1'b1;
            s_q.clk_s2 <= 1'b1;
            s_q.clk_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : ssi_readout
`default_nettype wire

// file: logic/ssi_readout_params.svh
`ifndef SSI_READOUT_PARAMS_SVH
`define SSI_READOUT_PARAMS_SVH

// Module clock rate in kHz.
`define PCLK_KHZ 40000

// Link rates in kHz and link half-period in module clock cycles.
`define RATE_125_KHZ 125
`define RATE_250_KHZ 250
`define RATE_500_KHZ 500
`define RATE_1000_KHZ 1000
`define HALF_CYC(khz) ((`PCLK_KHZ) / (2 * (khz)))

// Encoder monostable limits in us and in module clock cycles.
`define MONO_MIN_US 15
`define MONO_MAX_US 64
`define MONO_MIN_CYC ((`MONO_MIN_US * `PCLK_KHZ + 999) / 1000)
`define MONO_MAX_CYC ((`MONO_MAX_US * `PCLK_KHZ) / 1000)

// Frame geometry.
`define FRAME_SHORT 5'h0d
`define FRAME_LONG 5'h19
`define STEP_FIELD 4'hd
`define TURN_FIELD 4'hc

// Register byte offsets.
`define REG_CTRL 12'h000
`define REG_CONFIG 12'h004
`define REG_STATUS 12'h008
`define REG_POSITION 12'h00c
`define REG_RAW 12'h010
`define REG_IRQ_STATUS 12'h014
`define REG_IRQ_CLEAR 12'h018
`define REG_IRQ_ENABLE 12'h01c

// Field positions.
`define CTRL_EN_BIT 0
`define CTRL_LISTEN_BIT 1
`define CTRL_LAYOUT_LSB 2
`define CTRL_RATE_LSB 5
`define CONFIG_STEP_LSB 0
`define CONFIG_TURN_LSB 4
`define STAT_BUSY_BIT 0
`define STAT_FRAME_ERR_BIT 1
`define STAT_WIRE_BREAK_BIT 2
`define STAT_EXT_FAULT_BIT 3
`define STAT_INT_FAULT_BIT 4
`define STAT_VALID_BIT 5
`define IRQ_DONE_BIT 0
`define IRQ_FRAME_ERR_BIT 1
`define IRQ_WIRE_BREAK_BIT 2
`define IRQ_CFG_ERR_BIT 3

// Reset values.
`define CTRL_RST 8'h00
`define STEP_RST 4'hd
`define TURN_RST 4'hc
`define IRQ_EN_RST 4'h0

`endif

// file: logic/ssi_readout_pkg.sv
package ssi_readout_pkg;

    // Layout field encodings.
    typedef enum logic [2:0] {
        LAYOUT_HALF13 = 3'h0,
        LAYOUT_RJ13 = 3'h1,
        LAYOUT_RJ25 = 3'h2,
        LAYOUT_FIR25 = 3'h3,
        LAYOUT_HALF25 = 3'h4
    } layout_type;

    typedef enum logic [1:0] {
        RATE_125K = 2'h0,
        RATE_250K = 2'h1,
        RATE_500K = 2'h2,
        RATE_1M = 2'h3
    } rate_type;

    typedef enum {
        ST_IDLE,
        ST_MONO,
        ST_LOW,
        ST_HIGH,
        ST_LISTEN_WAIT,
        ST_LISTEN_RX
    } fsm_type;

    // Software settings.
    typedef struct packed {
        logic enable;
        logic listen;
        layout_type layout;
        rate_type rate;
        logic [3:0] step_bits;
        logic [3:0] turn_bits;
    } settings_type;

    // Whole block state.
    typedef struct packed {
        fsm_type state;
        settings_type cfg;
        logic [7:0] div_cnt;
        logic [4:0] bit_cnt;
        logic [11:0] gap_cnt;
        logic [24:0] shift;
        logic [24:0] raw;
        logic [24:0] position;
        logic clk_out;
        logic clk_oe;
        logic clk_s1;
        logic clk_s2;
        logic clk_prev;
        logic data_s1;
        logic data_s2;
        logic frame_err;
        logic wire_break;
        logic int_fault;
        logic valid;
        logic [3:0] irq_status;
        logic [3:0] irq_en;
        logic [31:0] prdata;
    } state_type;

endpackage : ssi_readout_pkg

// file: tb/ssi_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_encoder_model (
    input wire logic pclk,
    input wire logic link_clk,
    input wire logic [24:0] word,
    input wire logic [4:0] bits,
    input wire logic broken,
    input wire logic no_stop,
    output logic data
);
    logic busy, clk_q;
    logic [4:0] idx;
    int idle;
    initial begin
        busy = 0;
        clk_q = 1;
        idx = 0;
        idle = 0;
        data = 1;
    end
    // One Gray bit per rise, MSB first; low for a 20 us monostable, then high; broken reads low.
    always @(posedge pclk) begin
        clk_q <= link_clk;
        idle <= (link_clk != clk_q) ? 0 : idle + 1;
        if (broken) data <= 1'b0;
        else if (!busy && clk_q && !link_clk) begin
            busy <= 1'b1;
            idx <= bits;
        end else if (busy && !clk_q && link_clk) begin
            data <= (idx != 5'h0) ? word[idx-5'h1] : no_stop;
            idx <= (idx != 5'h0) ? idx - 5'h1 : 5'h0;
        end else if (!busy || idle > 800) begin
            busy <= 1'b0;
            data <= 1'b1;
        end
    end
endmodule : ssi_encoder_model
`default_nettype wire

// file: tb/ssi_readout_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Helpers mirror control writes and time the link clock.
module ssi_readout_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic enc_clk_o,
    input wire logic enc_clk_oe,
    input wire logic [24:0] position,
    input wire logic position_valid,
    input wire logic internal_fault_indicator,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] ctrl_q;
    logic [3:0] ien_q;
    logic [7:0] low_q, hi_q;
    logic [4:0] fall_q;
    logic wr;
    assign wr = psel && penable && pwrite;
    // A 200-cycle high run outlasts any half period, so it marks a frame gap.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 2'h0;
            ien_q <= 4'h0;
            low_q <= 8'h00;
            hi_q <= 8'h00;
            fall_q <= 5'h00;
        end else begin
            if (wr && paddr == 12'h000) ctrl_q <= pwdata[1:0];
            if (wr && paddr == 12'h01c) ien_q <= pwdata[3:0];
            low_q <= (enc_clk_oe && !enc_clk_o) ? low_q + 8'h01 : 8'h00;
            hi_q <= !(enc_clk_oe && enc_clk_o) ? 8'h00 : (hi_q == 8'hc8 ? hi_q : hi_q + 8'h01);
            fall_q <= !enc_clk_oe ? 5'h00 : (hi_q == 8'hc8 ? 5'h00 : fall_q) + {4'h0, $fell(enc_clk_o)};
        end
    end
    half_len_a: assert property ($rose(enc_clk_o) && enc_clk_oe |-> low_q inside {8'h14, 8'h28, 8'h50, 8'ha0})
        else $error("link clock half period off");
    frame_bits_a: assert property (hi_q == 8'hc7 |-> fall_q inside {5'h00, 5'h0e, 5'h1a})
        else $error("frame clock count off");
    listen_oe_a: assert property (ctrl_q == 2'h3 && $past(ctrl_q) == 2'h3 |-> !enc_clk_oe)
        else $error("clock driven while listening");
    idle_oe_a: assert property (!ctrl_q[0] && !$past(ctrl_q[0]) |-> !enc_clk_oe)
        else $error("clock driven while disabled");
    pos_valid_a: assert property (!$stable(position) |-> position_valid)
        else $error("position moved without valid");
    bad_cfg_a: assert property (wr && paddr == 12'h000 && pwdata[0] && pwdata[4:2] == 3'h7
        |-> ##[1:3] internal_fault_indicator)
        else $error("bad layout not flagged");
    err_resp_a: assert property (psel && penable && paddr >= 12'h020 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    irq_mask_a: assert property (irq |-> ien_q != 4'h0)
        else $error("irq with all sources masked");
    cover property ($rose(position_valid));
    cover property ($rose(internal_fault_indicator));
    cover property (hi_q == 8'hc7 && fall_q == 5'h1a);
endmodule : ssi_readout_checker

bind ssi_readout ssi_readout_checker ssi_readout_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .enc_clk_o(enc_clk_o), .enc_clk_oe(enc_clk_oe), .position(position), .position_valid(position_valid),
    .internal_fault_indicator(internal_fault_indicator), .irq(irq));
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clk_o, clk_oe, data, valid, ext_f, int_f, irq;
    logic lclk, broken, no_stop, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [24:0] position, word;
    logic [4:0] bits;
    int err_count, n_compared, cyc;
    wire logic link = clk_oe ? clk_o : lclk;
    ssi_readout ssi_readout_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_clk_i(link),
        .enc_clk_o(clk_o), .enc_clk_oe(clk_oe), .enc_data_i(data), .position(position), .position_valid(valid),
        .external_fault_indicator(ext_f), .internal_fault_indicator(int_f), .irq(irq));
    ssi_encoder_model ssi_encoder_model_i (.pclk(pclk), .link_clk(link), .word(word), .bits(bits),
        .broken(broken), .no_stop(no_stop), .data(data));
    // The clock runs at 40 MHz.
    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    // A hang ends the run as a mismatch.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            end_sim();
        end
    end
    function automatic logic [24:0] gray(input logic [24:0] b);
        return b ^ (b >> 1);
    endfunction : gray
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task rst;
        presetn <= 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
    endtask : rst
    // In listen mode the bench clocks 200 ns periods in the master's place.
    task run(input logic [31:0] ctrl, input logic [24:0] val, input logic [4:0] n);
        word <= gray(val);
        bits <= n;
        apb(1, 12'h018, 32'hf);
        apb(1, 12'h000, ctrl);
        if (ctrl[1]) repeat (14) begin
            repeat (4) @(posedge pclk);
            lclk <= 1'b0;
            repeat (4) @(posedge pclk);
            lclk <= 1'b1;
        end
        while (irq !== 1'b1) @(posedge pclk);
        apb(1, 12'h000, 0);
        apb(0, 12'h014, 0);
        $display("test ctrl %h done", ctrl);
    endtask : run
    initial begin
        {psel, penable, pwrite, paddr, pwdata, broken, no_stop, word, bits, err_count, n_compared, cyc} = 0;
        lclk = 1;
        rst();
        apb(0, 12'h004, 0);
        chk("config", 32'hcd, rd);
        apb(0, 12'h020, 0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1, 12'h01c, 32'hf);
        run(32'h69, 25'h1a5_5a5a, 5'h19);
        chk("rj25", 32'h1a5_5a5a, {7'h0, position});
        chk("valid", 32'h1, {31'h0, valid});
        run(32'h4d, 25'h0ff_f001, 5'h19);
        chk("fir25", 32'h0ff_f001, {7'h0, position});
        run(32'h65, 25'h1234, 5'h0d);
        chk("rj13", 32'h1234, {7'h0, position});
        chk("done", 32'h1, rd & 32'h1);
        no_stop <= 1;
        run(32'h65, 25'h0777, 5'h0d);
        chk("kept", 32'h1234, {7'h0, position});
        chk("frame_err", 32'h2, rd & 32'h2);
        chk("ext_f", 32'h1, {31'h0, ext_f});
        no_stop <= 0;
        broken <= 1;
        run(32'h65, 25'h0, 5'h0d);
        chk("break", 32'h4, rd & 32'h4);
        broken <= 0;
        apb(1, 12'h000, 32'h1d);
        repeat (3) @(posedge pclk);
        chk("int_f", 32'h1, {31'h0, int_f});
        apb(0, 12'h000, 0);
        chk("off", 32'h0, rd & 32'h1);
        rst();
        apb(1, 12'h01c, 32'hf);
        run(32'h07, 25'h0abc, 5'h0d);
        chk("listen", 32'h0abc, {7'h0, position});
        chk("oe", 32'h0, {31'h0, clk_oe});
        end_sim();
    end
endmodule : testbench
`default_nettype wire
